// ### hdl/gtc_defines.vh
// Purpose: constants for the gated 16-bit timer/counter
// Assumes: APB byte addresses, 8-bit registers in the low data bits
// Notes: Behaviour list below
//
// Behaviour
// (RQ1) 16-bit counter, high/low bytes accessible
// (RQ2) source 00 inst, 01 sys, 10 external
// (RQ3) pin counting waits for first falling edge
// (RQ4) prescale 1, 2, 4, 8
// (RQ5) bit 3 picks oscillator over pin
// (RQ6) sync bit bypasses synchroniser for source 10
// (RQ7) bit 1 selects buffered 16-bit access
// (RQ8) bit 0 runs counter, clear holds
// (RQ9) gate enable ignored when off
// (RQ10) polarity picks counting gate level
// (RQ11) toggle flip-flop, cleared when mode off
// (RQ12) single pulse logic controls the gate
// (RQ13) armed status bit, cleared with mode
// (RQ14) gate value readable, independent of enable
// (RQ15) gate source: cmp2, cmp1, match, pin
// (RQ16) software writes gate control first
// (RQ17) software avoids system clock for capture
// (RQ18) low read copies high into buffer
// (RQ19) low write loads buffered high too
// (RQ20) buffered mode hides real high byte
// (RQ21) only low-byte write clears prescaler
// (RQ22) force-run keeps secondary oscillator running
// (RQ23) wrap to zero sets overflow flag
// (RQ24) pulse trailing edge clears status, blocks
// (RQ25) gate value fall sets gate event flag
`ifndef GTC_DEFINES_VH
`define GTC_DEFINES_VH
`define GTC_ADDR_CTRL 12'h000
`define GTC_ADDR_GATE 12'h004
`define GTC_ADDR_OSC 12'h008
`define GTC_ADDR_LOW 12'h00c
`define GTC_ADDR_HIGH 12'h010
`define GTC_ADDR_FLAGS 12'h014
`define GTC_B_RUN 0
`define GTC_B_WIDE 1
`define GTC_B_SYNCBYP 2
`define GTC_B_OSCEN 3
`define GTC_B_PS_LO 4
`define GTC_B_CS_LO 6
`define GTC_B_GSS_LO 0
`define GTC_B_GVAL 2
`define GTC_B_GGO 3
`define GTC_B_SPM 4
`define GTC_B_GTM 5
`define GTC_B_GPOL 6
`define GTC_B_GE 7
`define GTC_B_FORCE 3
`define GTC_B_SYSOSC 6
`define GTC_B_OVF 0
`define GTC_B_GEVT 1
`define GTC_CS_INST 2'h0
`define GTC_CS_SYS 2'h1
`define GTC_CS_EXT 2'h2
`define GTC_INST_DIV 2'h3
`define GTC_RESET_BYTE 8'h00
`endif

// ### hdl/gtc_timer.v
// Purpose: gated 16-bit timer/counter with APB register access
// Assumes: all inputs synchronous to pclk; external clocks are slow levels
// Notes: instruction clock is pclk/4; flags are cleared by writing one
`timescale 1ns/1ps
`default_nettype none
`include "gtc_defines.vh"
module gtc_timer (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire external_count_input,
    input wire secondary_oscillator,
    input wire gate_pin,
    input wire companion_match,
    input wire comparator1_out,
    input wire comparator2_out,
    input wire system_on_secondary_osc,
    output reg secondary_osc_run,
    output reg overflow_pulse
);
    // ****************************************
    // registers
    // ****************************************
    reg [7:0] ctrl_q;
    reg [7:0] gctl_q;
    reg force_run_q;
    reg [15:0] count_q;
    reg [7:0] hbuf_q;
    reg [2:0] pre_q;
    reg [1:0] inst_q;
    reg ovf_flag_q;
    reg gevt_flag_q;
    reg ext_s1_q, ext_s2_q, ext_prev_q, ext_armed_q;
    reg tog_q, gsrc_prev_q, gval_q, pulse_seen_q;

    wire [1:0] cs = ctrl_q[`GTC_B_CS_LO+1:`GTC_B_CS_LO];
    wire [1:0] ps = ctrl_q[`GTC_B_PS_LO+1:`GTC_B_PS_LO];
    wire run = ctrl_q[`GTC_B_RUN];
    wire wide = ctrl_q[`GTC_B_WIDE];
    wire [1:0] gss = gctl_q[1:0];

    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire hit_ctrl = paddr == `GTC_ADDR_CTRL;
    wire hit_gate = paddr == `GTC_ADDR_GATE;
    wire hit_osc = paddr == `GTC_ADDR_OSC;
    wire hit_low = paddr == `GTC_ADDR_LOW;
    wire hit_high = paddr == `GTC_ADDR_HIGH;
    wire hit_flag = paddr == `GTC_ADDR_FLAGS;
    wire mapped = hit_ctrl | hit_gate | hit_osc | hit_low | hit_high | hit_flag;

    // ****************************************
    // clock source and edge
    // ****************************************
    // external source: oscillator or pin
    wire ext_raw = ctrl_q[`GTC_B_OSCEN] ? secondary_oscillator : external_count_input; // RQ5
    // bypass the two-stage synchroniser when requested
    wire ext_lvl = ctrl_q[`GTC_B_SYNCBYP] ? ext_raw : ext_s2_q; // RQ6
    wire ext_rise = ext_lvl && !ext_prev_q && ext_armed_q; // RQ3
    wire inst_tick = inst_q == `GTC_INST_DIV;
    reg src_tick;
    always @* begin
        case (cs) // RQ2
            `GTC_CS_INST: src_tick = inst_tick;
            `GTC_CS_SYS: src_tick = 1'b1;
            `GTC_CS_EXT: src_tick = ext_rise;
            default: src_tick = 1'b0;
        endcase
    end
    reg pre_tick;
    always @* begin
        case (ps) // RQ4
            2'h0: pre_tick = src_tick;
            2'h1: pre_tick = src_tick && pre_q[0];
            2'h2: pre_tick = src_tick && (pre_q[1:0] == 2'h3);
            default: pre_tick = src_tick && (pre_q == 3'h7);
        endcase
    end

    // ****************************************
    // gate
    // ****************************************
    reg gsrc;
    always @* begin
        case (gss) // RQ15
            2'h3: gsrc = comparator2_out;
            2'h2: gsrc = comparator1_out;
            2'h1: gsrc = companion_match;
            default: gsrc = gate_pin;
        endcase
    end
    wire gsrc_rise = gsrc && !gsrc_prev_q;
    wire gtm = gctl_q[`GTC_B_GTM];
    wire spm = gctl_q[`GTC_B_SPM];
    wire ggo = gctl_q[`GTC_B_GGO];
    wire gpol = gctl_q[`GTC_B_GPOL];
    wire gate_lvl = gtm ? tog_q : gsrc; // RQ11
    wire gate_act = gpol ? gate_lvl : !gate_lvl; // RQ10
    // single pulse: active only from arming through the trailing edge
    wire gate_eff = spm ? (ggo && pulse_seen_q && gate_act) : gate_act; // RQ12
    wire pulse_end = spm && ggo && pulse_seen_q && !gate_act; // RQ24
    wire gate_ok = !gctl_q[`GTC_B_GE] || gate_eff; // RQ9
    wire cnt_en = run && gate_ok && pre_tick; // RQ8
    wire gval_fall = gval_q && !gate_eff; // RQ25

    wire wr_low = wr && hit_low;
    wire wr_high = wr && hit_high;
    wire wr_gate = wr && hit_gate;

    // ****************************************
    // sequential logic
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `GTC_RESET_BYTE;
            gctl_q <= `GTC_RESET_BYTE;
            force_run_q <= 1'b0;
            count_q <= 16'h0000;
            hbuf_q <= `GTC_RESET_BYTE;
            pre_q <= 3'h0;
            inst_q <= 2'h0;
            ovf_flag_q <= 1'b0;
            gevt_flag_q <= 1'b0;
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_prev_q <= 1'b0;
            ext_armed_q <= 1'b0;
            tog_q <= 1'b0;
            gsrc_prev_q <= 1'b0;
            gval_q <= 1'b0;
            pulse_seen_q <= 1'b0;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            secondary_osc_run <= 1'b0;
            overflow_pulse <= 1'b0;
        end else begin
            inst_q <= inst_q + 2'h1;
            ext_s1_q <= ext_raw;
            ext_s2_q <= ext_s1_q;
            ext_prev_q <= ext_lvl;
            if (cs != `GTC_CS_EXT) begin
                ext_armed_q <= 1'b0;
            end else if (ext_prev_q && !ext_lvl) begin
                // arm only on a real falling edge, a low level alone is not enough
                ext_armed_q <= 1'b1; // RQ3
            end
            gsrc_prev_q <= gsrc;
            if (!gtm) begin
                tog_q <= 1'b0; // RQ11
            end else if (gsrc_rise) begin
                tog_q <= !tog_q;
            end
            gval_q <= gate_eff; // RQ14
            // single pulse: wait for active level after arming
            if (!spm || !ggo) begin
                pulse_seen_q <= 1'b0;
            end else if (gate_act) begin
                pulse_seen_q <= 1'b1;
            end
            secondary_osc_run <= force_run_q | ctrl_q[`GTC_B_OSCEN]; // RQ22
            overflow_pulse <= 1'b0;
            // ---- counter and prescaler
            if (wr_low) begin
                pre_q <= 3'h0; // RQ21
            end else if (run && gate_ok && src_tick) begin
                pre_q <= pre_q + 3'h1;
            end
            if (wr_low) begin
                count_q[7:0] <= pwdata[7:0]; // RQ1
                if (wide) begin
                    count_q[15:8] <= hbuf_q; // RQ19
                end
            end else if (wr_high && !wide) begin
                count_q[15:8] <= pwdata[7:0]; // RQ20
            end else if (cnt_en) begin
                count_q <= count_q + 16'h0001; // RQ23
                if (count_q == 16'hffff) begin
                    overflow_pulse <= 1'b1;
                end
            end
            if (wr_high && wide) begin
                hbuf_q <= pwdata[7:0]; // RQ19
            end else if (rd && hit_low && wide) begin
                hbuf_q <= count_q[15:8]; // RQ18
            end
            // ---- registers
            if (wr && hit_ctrl) begin
                ctrl_q <= pwdata[7:0]; // RQ7
            end
            if (wr_gate) begin
                gctl_q <= {pwdata[7:3], 1'b0, pwdata[1:0]};
                if (!pwdata[`GTC_B_SPM]) begin
                    gctl_q[`GTC_B_GGO] <= 1'b0; // RQ13
                end
            end else if (!spm || pulse_end) begin
                gctl_q[`GTC_B_GGO] <= 1'b0; // RQ24
            end
            if (wr && hit_osc) begin
                force_run_q <= pwdata[`GTC_B_FORCE];
            end
            // flags: write one clears, a new event wins
            if (cnt_en && count_q == 16'hffff && !(wr_low || (wr_high && !wide))) begin
                ovf_flag_q <= 1'b1; // RQ23
            end else if (wr && hit_flag && pwdata[`GTC_B_OVF]) begin
                ovf_flag_q <= 1'b0;
            end
            if (gval_fall) begin
                gevt_flag_q <= 1'b1; // RQ25
            end else if (wr && hit_flag && pwdata[`GTC_B_GEVT]) begin
                gevt_flag_q <= 1'b0;
            end
            // ---- apb answer one cycle after setup
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite) begin
                prdata <= 32'h00000000;
                if (hit_ctrl) prdata[7:0] <= ctrl_q;
                if (hit_gate) prdata[7:0] <= {gctl_q[7:3], gval_q, gctl_q[1:0]};
                if (hit_osc) prdata[7:0] <= {1'b0, system_on_secondary_osc, 2'b00, force_run_q, 3'b000};
                if (hit_low) prdata[7:0] <= count_q[7:0];
                if (hit_high) prdata[7:0] <= wide ? hbuf_q : count_q[15:8]; // RQ20
                if (hit_flag) prdata[7:0] <= {6'h00, gevt_flag_q, ovf_flag_q};
            end
        end
    end
endmodule
`default_nettype wire

// ### test/gtc_far_end.sv
// Purpose: count clocks and gate sources around the timer
// Assumes: driven from pclk edges
// Notes: gate levels are set by the bench directly
`timescale 1ns/1ps
`default_nettype none
module gtc_far_end (
    input wire logic clk,
    output logic ext_cnt,
    output logic osc,
    output logic gate_pin,
    output logic match,
    output logic cmp1,
    output logic cmp2
);
    // ********************
    // stimulus
    // ********************
    initial begin
        ext_cnt = 1'b0;
        osc = 1'b1;
        {gate_pin, match, cmp1, cmp2} = 4'h0;
    end
    // every pulse falls before it rises
    task automatic pulse(input logic sel, input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            if (sel) osc <= 1'b0; else ext_cnt <= 1'b0;
            repeat (4) @(posedge clk);
            if (sel) osc <= 1'b1; else ext_cnt <= 1'b1;
        end
        repeat (6) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ### test/gtc_timer_sva.sv
// Purpose: bus and output checks for gtc_timer
// Assumes: zero-wait slave, single pclk domain
// Notes: bound to every gtc_timer instance
`timescale 1ns/1ps
`default_nettype none
module gtc_timer_sva (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire secondary_osc_run,
    input wire overflow_pulse
);
    // ********************
    // checks
    // ********************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire setup = psel && !penable;
    wire bad = (paddr > 12'h014) || (paddr[1:0] != 2'h0);
    a_ready_after_setup: assert property (setup |=> pready) else $error("ready missing");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready too long");
    a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray ready");
    a_err_unmapped: assert property (setup && bad |=> pslverr) else $error("no error");
    a_err_mapped: assert property (setup && !bad |=> !pslverr) else $error("false error");
    a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits");
    a_ovf_pulse: assert property (overflow_pulse |=> !overflow_pulse) else $error("long pulse");
    a_osc_enable: assert property (setup && pwrite && paddr == 12'h0 && pwdata[3] |=> ##[1:2] secondary_osc_run)
        else $error("osc not run");
    c_unmapped: cover property (setup && bad);
    c_overflow: cover property (overflow_pulse);
    c_osc_run: cover property (secondary_osc_run);
endmodule
bind gtc_timer gtc_timer_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .secondary_osc_run(secondary_osc_run), .overflow_pulse(overflow_pulse));
`default_nettype wire

// ### test/tb_gated_16bit_timer_counter.sv
// Purpose: self-checking bench for gtc_timer
// Assumes: zero-wait slave, pclk at 125 MHz
// Notes: gate control written before timer control
`timescale 1ns/1ps
`default_nettype none
`include "gtc_defines.vh"
module tb_gated_16bit_timer_counter;
    localparam logic [11:0] CT = `GTC_ADDR_CTRL, GT = `GTC_ADDR_GATE, OS = `GTC_ADDR_OSC;
    localparam logic [11:0] LO = `GTC_ADDR_LOW, HI = `GTC_ADDR_HIGH, FL = `GTC_ADDR_FLAGS;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    wire [31:0] prdata;
    wire pready, pslverr, osc_run, ext, osc, gp, mt, c1, c2, ovf_p;
    int errors = 0, cmp_count = 0, cyc = 0, ovf_n = 0;
    always #4 pclk = ~pclk;
    gtc_far_end fe (.clk(pclk), .ext_cnt(ext), .osc(osc), .gate_pin(gp), .match(mt), .cmp1(c1), .cmp2(c2));
    gtc_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_count_input(ext), .secondary_oscillator(osc), .gate_pin(gp), .companion_match(mt),
        .comparator1_out(c1), .comparator2_out(c2), .system_on_secondary_osc(1'b1),
        .secondary_osc_run(osc_run), .overflow_pulse(ovf_p));
    always @(posedge pclk) if (ovf_p === 1'b1) ovf_n++;
    // ********************
    // helpers
    // ********************
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h0); chk(rd, exp);
    endtask
    task automatic results;
        if (errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++; results;
        end
    end
    // ********************
    // scenarios
    // ********************
    task automatic t_reset;
        rdc(CT, 0);
        rdc(OS, 32'h40);
        apb(1'b0, 12'h018, 8'h0); chk({31'h0, err}, 1);
        apb(1'b1, OS, 8'h08); @(posedge pclk); chk({31'h0, osc_run}, 1);
        apb(1'b1, OS, 8'h00);
    endtask
    task automatic t_count;
        apb(1'b1, LO, 0); apb(1'b1, CT, 8'h81); fe.ext_cnt <= 1'b1; fe.pulse(0, 3);
        apb(1'b1, CT, 8'h80); fe.pulse(0, 2); rdc(LO, 3);
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, CT, 8'h80); apb(1'b1, LO, 0);
            apb(1'b1, CT, {2'h2, p[1:0], 1'b0, p[1] & p[0], 2'h1}); fe.pulse(0, 8);
            rdc(LO, 8 >> p);
        end
        apb(1'b1, CT, 8'h80); apb(1'b1, LO, 0); apb(1'b1, CT, 8'h89); fe.pulse(0, 2); fe.pulse(1, 5);
        chk({31'h0, osc_run}, 1);
        rdc(LO, 5);
        apb(1'b1, CT, 8'h80); apb(1'b1, LO, 0); apb(1'b1, CT, 8'h91); fe.pulse(0, 1);
        apb(1'b1, HI, 0); fe.pulse(0, 1); rdc(LO, 1);
        apb(1'b1, LO, 0); fe.pulse(0, 1); rdc(LO, 0);
    endtask
    task automatic t_wide;
        apb(1'b1, CT, 8'h02); apb(1'b1, HI, 8'h5a); apb(1'b1, LO, 8'hc3); apb(1'b1, CT, 0);
        rdc(HI, 8'h5a);
        rdc(LO, 8'hc3);
        apb(1'b1, HI, 8'h77); apb(1'b1, CT, 8'h02); apb(1'b1, HI, 8'h99);
        rdc(LO, 8'hc3);
        rdc(HI, 8'h77);
        apb(1'b1, CT, 0); rdc(HI, 8'h77);
    endtask
    task automatic t_ovf;
        apb(1'b1, HI, 8'hff); apb(1'b1, LO, 8'hff); apb(1'b1, CT, 8'h81); fe.pulse(0, 1);
        rdc(LO, 0);
        rdc(HI, 0);
        rdc(FL, 1);
        chk(ovf_n, 1);
        apb(1'b1, FL, 8'h01); rdc(FL, 0);
        apb(1'b1, CT, 0);
    endtask
    task automatic t_gate;
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, GT, 8'hc0 | s); apb(1'b1, FL, 8'h03); apb(1'b1, LO, 0);
            apb(1'b1, CT, 8'h81); fe.pulse(0, 2);
            {fe.cmp2, fe.cmp1, fe.match, fe.gate_pin} <= 4'h1 << s;
            fe.pulse(0, 2); rdc(LO, 2);
            rdc(GT, 8'hc4 | s);
            {fe.cmp2, fe.cmp1, fe.match, fe.gate_pin} <= 4'h0;
            repeat (6) @(posedge pclk);
            rdc(FL, 2);
            apb(1'b1, CT, 0);
        end
    endtask
    task automatic t_mode;
        apb(1'b1, CT, 0); apb(1'b1, GT, 0); apb(1'b1, LO, 0);
        apb(1'b1, CT, 8'h41); apb(1'b1, CT, 8'h40); rdc(LO, 3);
        apb(1'b1, CT, 0); apb(1'b1, FL, 8'h03); apb(1'b1, LO, 0);
        apb(1'b1, GT, 8'hd0); apb(1'b1, GT, 8'hd8); apb(1'b1, CT, 8'h81); fe.pulse(0, 1);
        rdc(GT, 8'hd8);
        fe.gate_pin <= 1'b1; fe.pulse(0, 2); fe.gate_pin <= 1'b0; repeat (4) @(posedge pclk);
        rdc(GT, 8'hd0);
        fe.gate_pin <= 1'b1; fe.pulse(0, 2); fe.gate_pin <= 1'b0;
        rdc(LO, 2);
        apb(1'b1, GT, 8'hd8); apb(1'b1, GT, 8'hc8); rdc(GT, 8'hc0);
        apb(1'b1, GT, 8'he0); apb(1'b1, LO, 0);
        fe.gate_pin <= 1'b1; repeat (2) @(posedge pclk); fe.gate_pin <= 1'b0; fe.pulse(0, 2);
        fe.gate_pin <= 1'b1; fe.pulse(0, 2); rdc(LO, 2);
        fe.gate_pin <= 1'b0; apb(1'b1, CT, 0);
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset; t_count; t_wide; t_ovf; t_gate; t_mode;
        results;
    end
endmodule
`default_nettype wire
